// [dac_load_update_control.sv]
/*
 * update control for a quad serially loaded dac: shifts 32-bit frames,
 * keeps input and dac registers per channel, applies update triggers.
 * assumes sclk, frame_sync_n, sdin, load_strobe_n and power_down come
 * from pins asynchronous to clk; sclk much slower than clk.
 */
//
// Contract
// - synchronous update on 32nd falling sclk edge
// - async mode: strobe falling edge copies inputs
// - command 0011 writes channel, updates all
// - override 0: channel follows strobe pin
// - override 1: update at frame end
// - command 0110 loads override from bits 3:0
// - override resets to all zero
// - override frame: cmd 27:24, select 3:0
// - strobe ignored during power-on blanking
// - power-up output: input if strobe low
`timescale 1ns/10ps
`default_nettype none
module dac_load_update_control
	import dac_update_pkg::*;
(
	input  wire logic                clk,            // 40 mhz system clock
	input  wire logic                rstn,           // async reset, active low
	input  wire logic                sclk,           // serial clock pin
	input  wire logic                frame_sync_n,   // frame select pin, low active
	input  wire logic                sdin,           // serial data pin
	input  wire logic                load_strobe_n,  // load strobe pin, low active
	input  wire logic [NUM_CH-1:0]   power_down,     // per-channel power-down level
	output logic      [NUM_CH*DATA_W-1:0] dac_out,   // output codes, a in low bits
	output logic      [NUM_CH-1:0]   override_o,     // override register contents
	output logic                     por_busy        // power-on blanking active
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [3:0] pins_s; // {sclk, fsync_n, sdin, strobe_n}

	pin_sync #(
		.W    (4),
		.INIT (4'hD)
	) u_sync (
		.clk    (clk),
		.rstn   (rstn),
		.pin_i  ({sclk, frame_sync_n, sdin, load_strobe_n}),
		.sync_o (pins_s)
	);

	logic [NUM_CH-1:0] pd_s; // synchronised power-down levels

	pin_sync #(
		.W    (NUM_CH),
		.INIT ('0)
	) u_sync_pd (
		.clk    (clk),
		.rstn   (rstn),
		.pin_i  (power_down),
		.sync_o (pd_s)
	);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic                   sclk_prev_q, sclk_prev_d;    // last sclk sample
	logic                   strobe_prev_q, strobe_prev_d; // last strobe sample
	logic [FRAME_BITS-1:0]  shift_q, shift_d;             // serial shifter
	logic [5:0]             count_q, count_d;             // bits in this frame
	logic [NUM_CH-1:0]      override_q, override_d;       // per-channel override
	logic [DATA_W-1:0]      inreg_q [NUM_CH];             // input registers
	logic [DATA_W-1:0]      inreg_d [NUM_CH];
	logic [DATA_W-1:0]      dacreg_q [NUM_CH];            // dac registers
	logic [DATA_W-1:0]      dacreg_d [NUM_CH];
	logic [NUM_CH-1:0]      pd_prev_q, pd_prev_d;         // last power-down level
	logic [NUM_CH*DATA_W-1:0] out_q, out_d;               // registered outputs
	logic [5:0]             por_q, por_d;                 // blanking counter
	logic                   busy_q, busy_d;               // registered blanking flag

	// decoded helpers
	logic                   sclk_fall;    // falling sclk sample
	logic                   strobe_fall;  // falling strobe sample
	logic                   frame_done;   // 32nd falling edge seen
	logic [FRAME_BITS-1:0]  frame;        // completed frame word
	logic [3:0]             cmd;          // command field
	logic [3:0]             addr;         // channel address field
	logic [DATA_W-1:0]      data;         // data word
	logic                   strobe_low;   // strobe level, blanked during por

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		sclk_prev_d   = pins_s[3];
		strobe_prev_d = pins_s[0];
		pd_prev_d     = pd_s;
		sclk_fall     = sclk_prev_q && !pins_s[3];
		// strobe activity is blanked while por runs
		strobe_fall   = strobe_prev_q && !pins_s[0] && (por_q == 6'h00);
		strobe_low    = !pins_s[0] && (por_q == 6'h00);
		por_d         = (por_q != 6'h00) ? por_q - 6'h01 : por_q;
		// flag tracks the next count so the pin comes straight from a flop
		busy_d        = (por_d != 6'h00);
		shift_d       = shift_q;
		count_d       = count_q;
		override_d    = override_q;
		frame_done    = 1'b0;
		// frame select high aborts and rearms the shifter
		if (pins_s[2]) begin
			count_d = 6'h00;
		end else if (sclk_fall && count_q < 6'(FRAME_BITS)) begin
			shift_d = {shift_q[FRAME_BITS-2:0], pins_s[1]};
			count_d = count_q + 6'h01;
			frame_done = (count_q == 6'(FRAME_BITS - 1));
		end
		frame = shift_d;
		cmd   = frame[CMD_MSB:CMD_LSB];       // top four bits ignored
		addr  = frame[ADDR_MSB:ADDR_LSB];
		data  = frame[DATA_MSB:DATA_LSB];
		for (int c = 0; c < NUM_CH; c++) begin
			inreg_d[c]  = inreg_q[c];
			dacreg_d[c] = dacreg_q[c];
		end
		if (frame_done) begin
			if (cmd == CMD_LOAD_OVERRIDE) begin
				// only select bits count, rest ignored
				override_d = frame[SEL_MSB:SEL_LSB];
			end
			for (int c = 0; c < NUM_CH; c++) begin
				if ((cmd == CMD_WRITE_INPUT || cmd == CMD_WRITE_UPD_ALL_SW ||
				     cmd == CMD_WRITE_UPD_ALL) &&
				    (addr == 4'(c) || addr == ADDR_ALL)) begin
					inreg_d[c] = data;
				end
			end
			for (int c = 0; c < NUM_CH; c++) begin
				// software update-all needs no strobe
				if (cmd == CMD_WRITE_UPD_ALL_SW || cmd == CMD_WRITE_UPD_ALL) begin
					dacreg_d[c] = inreg_d[c];
				end else if (cmd == CMD_UPDATE_DAC && (addr == 4'(c) || addr == ADDR_ALL)) begin
					dacreg_d[c] = inreg_d[c];
				// synchronous: override set or strobe held low
				end else if (cmd == CMD_WRITE_INPUT && (override_q[c] || strobe_low)) begin
					dacreg_d[c] = inreg_d[c];
				end
			end
		end
		// asynchronous update only for strobe-controlled channels
		for (int c = 0; c < NUM_CH; c++) begin
			if (strobe_fall && !override_q[c]) begin
				dacreg_d[c] = inreg_d[c];
			end
			// power-up with strobe low keeps the input value, not one cycle of it
			if (!pd_s[c] && pd_prev_q[c] && strobe_low) begin
				dacreg_d[c] = inreg_d[c];
			end
		end
		// output codes; powered-down channels hold their last value
		out_d = out_q;
		for (int c = 0; c < NUM_CH; c++) begin
			if (!pd_s[c]) begin
				if (pd_prev_q[c] && strobe_low) begin
					out_d[c*DATA_W +: DATA_W] = inreg_q[c];
				end else if (pd_prev_q[c]) begin
					out_d[c*DATA_W +: DATA_W] = dacreg_q[c];
				end else begin
					out_d[c*DATA_W +: DATA_W] = dacreg_q[c];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sclk_prev_q   <= 1'b1;
			strobe_prev_q <= 1'b1;
			pd_prev_q     <= '0;
			shift_q       <= '0;
			count_q       <= 6'h00;
			override_q    <= OVERRIDE_RESET;
			out_q         <= '0;
			por_q         <= POR_CYCLES;
			busy_q        <= 1'b1;
			for (int c = 0; c < NUM_CH; c++) begin
				inreg_q[c]  <= DAC_RESET;
				dacreg_q[c] <= DAC_RESET;
			end
		end else begin
			sclk_prev_q   <= sclk_prev_d;
			strobe_prev_q <= strobe_prev_d;
			pd_prev_q     <= pd_prev_d;
			shift_q       <= shift_d;
			count_q       <= count_d;
			override_q    <= override_d;
			out_q         <= out_d;
			por_q         <= por_d;
			busy_q        <= busy_d;
			for (int c = 0; c < NUM_CH; c++) begin
				inreg_q[c]  <= inreg_d[c];
				dacreg_q[c] <= dacreg_d[c];
			end
		end
	end

	assign dac_out    = out_q;
	assign override_o = override_q;
	assign por_busy   = busy_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	override_load_a: assert property (@(posedge clk) disable iff (!rstn)
		(frame_done && cmd == CMD_LOAD_OVERRIDE) |=> override_q == $past(frame[3:0]))
		else $error("override not loaded from frame");
	override_keep_a: assert property (@(posedge clk) disable iff (!rstn)
		!(frame_done && cmd == CMD_LOAD_OVERRIDE) |=> $stable(override_q))
		else $error("override changed without its command");
	sw_update_a: assert property (@(posedge clk) disable iff (!rstn)
		(frame_done && cmd == CMD_WRITE_UPD_ALL_SW) |=> dacreg_q[3] == inreg_q[3])
		else $error("software update-all missed a channel");
	override_sync_a: assert property (@(posedge clk) disable iff (!rstn)
		(frame_done && cmd == CMD_WRITE_INPUT && override_q[0] && addr == 4'h0)
		|=> dacreg_q[0] == inreg_q[0])
		else $error("override channel not updated at frame end");
	async_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		(frame_done && cmd == CMD_WRITE_INPUT && !override_q[1] && !strobe_low
		 && !strobe_fall) |=> $stable(dacreg_q[1]))
		else $error("dac register moved without strobe");
	strobe_load_a: assert property (@(posedge clk) disable iff (!rstn)
		(strobe_fall && !override_q[2]) |=> dacreg_q[2] == $past(inreg_d[2]))
		else $error("strobe edge did not load channel");
	por_blank_a: assert property (@(posedge clk) disable iff (!rstn)
		(por_q != 6'h00) |-> !strobe_fall)
		else $error("strobe seen during power-on blanking");
	frame_end_a: assert property (@(posedge clk) disable iff (!rstn)
		frame_done |-> (count_q == 6'(FRAME_BITS - 1)) && sclk_fall)
		else $error("frame ended on wrong edge");
	override_rst_a: assert property (@(posedge clk)
		$rose(rstn) |-> override_q == 4'h0)
		else $error("override not zero after reset");
endmodule : dac_load_update_control
`default_nettype wire

// [dac_update_pkg.sv]
/*
 * shared constants for the quad dac update-control logic: frame layout,
 * command codes, reset values, synchroniser depth.
 * assumes nothing beyond a systemverilog-capable tool flow.
 */
package dac_update_pkg;
	// ------------------------------------------------------------
	// frame layout
	// ------------------------------------------------------------
	localparam int FRAME_BITS   = 32;            // bits per serial frame
	localparam int CMD_MSB      = 27;            // command field top bit
	localparam int CMD_LSB      = 24;            // command field low bit
	localparam int ADDR_MSB     = 23;            // channel address field top bit
	localparam int ADDR_LSB     = 20;            // channel address field low bit
	localparam int DATA_MSB     = 19;            // data word top bit
	localparam int DATA_LSB     = 4;             // data word low bit
	localparam int SEL_MSB      = 3;             // channel select field top bit
	localparam int SEL_LSB      = 0;             // channel select field low bit
	localparam int NUM_CH       = 4;             // channels a..d
	localparam int DATA_W       = 16;            // dac word width
	localparam int SYNC_STAGES  = 2;             // flops on every pin input
	// ------------------------------------------------------------
	// command codes
	// ------------------------------------------------------------
	localparam logic [3:0] CMD_WRITE_INPUT   = 4'h0; // write input register n
	localparam logic [3:0] CMD_UPDATE_DAC    = 4'h1; // update dac register n
	localparam logic [3:0] CMD_WRITE_UPD_ALL = 4'h2; // write n, update all
	localparam logic [3:0] CMD_WRITE_UPD_ALL_SW = 4'h3; // write n, update all
	localparam logic [3:0] CMD_POWER         = 4'h4; // power up/down
	localparam logic [3:0] CMD_LOAD_OVERRIDE = 4'h6; // load override register
	localparam logic [3:0] ADDR_ALL          = 4'hF; // address all channels
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [3:0]  OVERRIDE_RESET = 4'h0;    // all channels follow strobe
	localparam logic [15:0] DAC_RESET      = 16'h0000; // zero-scale code
	localparam logic [5:0]  POR_CYCLES     = 6'h10;   // por blanking length
endpackage : dac_update_pkg

// [pin_sync.sv]
/*
 * two-flop synchroniser for a vector of pin inputs.
 * assumes inputs are asynchronous to clk.
 */
`timescale 1ns/10ps
`default_nettype none
module pin_sync
	import dac_update_pkg::*;
#(
	parameter int          W     = 1,   // number of pins
	parameter logic [W-1:0] INIT = '0   // value held under reset
) (
	input  wire logic         clk,   // system clock
	input  wire logic         rstn,  // async reset, active low
	input  wire logic [W-1:0] pin_i, // raw pins
	output logic      [W-1:0] sync_o // synchronised pins
);
	// ------------------------------------------------------------
	// two stages; first stage read only by the second
	// ------------------------------------------------------------
	logic [W-1:0] meta_q;  // first stage
	logic [W-1:0] meta_d;  // first stage next
	logic [W-1:0] sync_q;  // second stage
	logic [W-1:0] sync_d;  // second stage next

	// next values
	always_comb begin
		meta_d = pin_i;
		sync_d = meta_q;
	end

	// registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= INIT;
			sync_q <= INIT;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_o = sync_q;
endmodule : pin_sync
`default_nettype wire

// [host_model.sv]
/* host side model: sends 32-bit serial frames msb first and drives the
   load strobe. assumes clk at 40 mhz; sclk period is 8 clk (200 ns). */
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input  wire logic clk,           // bench clock, paces sclk
	output logic      sclk,          // serial clock, idle high
	output logic      frame_sync_n,  // frame select, low active
	output logic      sdin,          // serial data
	output logic      load_strobe_n  // load strobe, low active
);
	// ------------------------------------------------------------
	// idle levels: sclk stands still high between frames
	// ------------------------------------------------------------
	initial begin
		sclk = 1'b1;
		frame_sync_n = 1'b1;
		sdin = 1'b0;
		load_strobe_n = 1'b1;
	end
	// ------------------------------------------------------------
	// frame sender, data changes while sclk high, taken on the fall
	// ------------------------------------------------------------
	task automatic send(input logic [31:0] w); // caller sits on a clk edge
		frame_sync_n <= 1'b0;
		for (int i = 31; i >= 0; i--) begin
			sdin <= w[i];
			repeat (4) @(posedge clk);
			sclk <= 1'b0;
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
		end
		repeat (4) @(posedge clk);
		frame_sync_n <= 1'b1;
		sdin <= ~w[0]; // released line must not show the last bit
		repeat (4) @(posedge clk);
	endtask : send
	// strobe may be pulsed or held low, both legal
	task automatic strobe(input logic v);
		@(posedge clk);
		load_strobe_n <= v;
		repeat (4) @(posedge clk);
	endtask : strobe
endmodule : host_model
`default_nettype wire

// [testbench.sv]
/* self-checking bench for the dac update control: host model on the
   serial side, outputs compared per channel. assumes dac_update_pkg. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module testbench;
	import dac_update_pkg::*;
	logic                     clk = 1'b0;      // 40 mhz
	logic                     rstn = 1'b0;     // async reset
	logic [NUM_CH-1:0]        power_down = '0; // per-channel power-down
	wire logic                sclk, frame_sync_n, sdin, load_strobe_n; // host pins
	logic [NUM_CH*DATA_W-1:0] dac_out;         // output codes
	logic [NUM_CH-1:0]        override_o;      // override register
	logic                     por_busy;        // blanking flag
	int                       bad_count = 0;   // mismatches
	int                       samples_checked = 0; // comparisons
	int                       cycles = 0;      // timeout counter
	// ------------------------------------------------------------
	// clock, parts, timeout
	// ------------------------------------------------------------
	always #12.5 clk = ~clk;
	host_model host_u (.clk(clk), .sclk(sclk), .frame_sync_n(frame_sync_n), .sdin(sdin),
		.load_strobe_n(load_strobe_n));
	dac_load_update_control dut_u (.clk(clk), .rstn(rstn), .sclk(sclk),
		.frame_sync_n(frame_sync_n), .sdin(sdin), .load_strobe_n(load_strobe_n),
		.power_down(power_down), .dac_out(dac_out), .override_o(override_o),
		.por_busy(por_busy));
	// about 12 frames of 273 clk each; generous ceiling
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			finish_test();
		end
	end
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] ch(input int i);
		return dac_out[i*DATA_W +: DATA_W];
	endfunction : ch
	// top nibble is don't-care, filled with junk on purpose
	task automatic wr(input logic [3:0] c, a, input logic [15:0] d, input logic [3:0] s);
		@(posedge clk);
		host_u.send({4'hC, c, a, d, s});
		repeat (8) @(posedge clk);
	endtask : wr
	task automatic pulse();
		host_u.strobe(1'b0);
		host_u.strobe(1'b1);
	endtask : pulse
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_async();
		wr(CMD_WRITE_INPUT, 4'h0, 16'h1234, 4'h0);
		`CHK("a held", 16'h0000, ch(0))
		pulse();
		`CHK("a strobed", 16'h1234, ch(0))
		$display("async test done");
	endtask : t_async
	task automatic t_sync();
		host_u.strobe(1'b0);
		wr(CMD_WRITE_INPUT, 4'h1, 16'h5678, 4'h0);
		`CHK("b frame end", 16'h5678, ch(1))
		host_u.strobe(1'b1);
		$display("sync test done");
	endtask : t_sync
	task automatic t_soft();
		wr(CMD_WRITE_INPUT, 4'h2, 16'hAAAA, 4'h0);
		`CHK("c held", 16'h0000, ch(2))
		wr(CMD_WRITE_UPD_ALL_SW, 4'h3, 16'hBBBB, 4'h0);
		`CHK("c sw load", 16'hAAAA, ch(2))
		`CHK("d sw load", 16'hBBBB, ch(3))
		$display("software load test done");
	endtask : t_soft
	task automatic t_override();
		wr(CMD_LOAD_OVERRIDE, 4'h9, 16'hFFFF, 4'h5); // junk in ignored bits
		`CHK("override", 4'h5, override_o)
		wr(CMD_WRITE_INPUT, 4'h0, 16'h1111, 4'h0);
		`CHK("a override", 16'h1111, ch(0))
		wr(CMD_WRITE_INPUT, 4'h1, 16'h2222, 4'h0);
		`CHK("b no override", 16'h5678, ch(1))
		pulse();
		`CHK("b strobed", 16'h2222, ch(1))
		$display("override test done");
	endtask : t_override
	task automatic t_power();
		wr(CMD_LOAD_OVERRIDE, 4'h0, 16'h0000, 4'h0);
		`CHK("override clear", 4'h0, override_o)
		power_down <= 4'h1;
		wr(CMD_WRITE_INPUT, 4'h0, 16'h3333, 4'h0);
		power_down <= 4'h0;
		repeat (8) @(posedge clk);
		`CHK("a power up", 16'h1111, ch(0))
		// second pass: strobe falls while down, power-up with strobe low
		power_down <= 4'h1;
		host_u.strobe(1'b0);
		`CHK("a held down", 16'h1111, ch(0))
		power_down <= 4'h0;
		repeat (8) @(posedge clk);
		`CHK("a up strobe low", 16'h3333, ch(0))
		host_u.strobe(1'b1);
		$display("power-up test done");
	endtask : t_power
	task automatic t_update();
		wr(CMD_WRITE_INPUT, 4'h2, 16'h4444, 4'h0);
		`CHK("c held again", 16'hAAAA, ch(2))
		wr(CMD_UPDATE_DAC, 4'h2, 16'h0000, 4'h0);
		`CHK("c cmd update", 16'h4444, ch(2))
		`CHK("d not updated", 16'hBBBB, ch(3))
		wr(CMD_WRITE_UPD_ALL, ADDR_ALL, 16'h5555, 4'h0);
		`CHK("a write all", 16'h5555, ch(0))
		`CHK("d write all", 16'h5555, ch(3))
		$display("update command test done");
	endtask : t_update
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		`CHK("dac reset", 64'h0, dac_out)
		`CHK("override reset", 4'h0, override_o)
		`CHK("por in reset", 1'b1, por_busy)
		rstn <= 1'b1;
		repeat (24) @(posedge clk);
		`CHK("por done", 1'b0, por_busy)
		t_async();
		t_sync();
		t_soft();
		t_override();
		t_power();
		t_update();
		finish_test();
	end
endmodule : testbench
`default_nettype wire
